// *** shared/rss_pkg.sv ***
// Shared constants and types for the serial clock/RAM slave access block.
// Assumes a 50 MHz system clock and a separate free-running link sampling clock.
package rss_pkg;
  localparam logic [6:0] SLAVE_ADDR = 7'h68;
  localparam int PTR_W = 6;
  localparam int MEM_BYTES = 64;
  localparam logic [5:0] CLK_LAST = 6'h07;
  localparam logic [5:0] RES_FIRST = 6'h10;
  localparam logic [5:0] RES_LAST = 6'h12;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam int CLK_MHZ = 50;
  // Recovery interval after power returns; figure is a plain default
  localparam int REC_TIME_US = 1000;
  localparam int REC_CYCLES = REC_TIME_US * CLK_MHZ;
  localparam int FIFO_DEPTH = 2;

  typedef struct packed {
    logic [PTR_W-1:0] addr;
    logic [7:0] data;
  } rss_wrrec_t;

  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_ADDR = 9'h002,
    ST_ACKA = 9'h004,
    ST_WADR = 9'h008,
    ST_ACKW = 9'h010,
    ST_WDAT = 9'h020,
    ST_ACKD = 9'h040,
    ST_RDAT = 9'h080,
    ST_RACK = 9'h100
  } rss_state_t;

  // Ignoring the bus until the next START is the idle state itself
  localparam rss_state_t ST_IGN = ST_IDLE;
endpackage

// *** core/rss_slave.sv ***
// Two-wire slave access to a 64-byte clock/control/RAM space.
// Assumes SCL/SDA come from pins (open drain), power-fail from a comparator pin,
// and a consumer of written bytes on the system clock.
`timescale 1ns/10ps
`default_nettype none
module rss_slave
  import rss_pkg::*;
#(
  parameter int REC_CYC = REC_CYCLES,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic clk, // System clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic linkClk, // Bus sampling clock
  input wire logic sclIn, // SCL pin level
  output logic sclOut, // SCL drive level
  output logic sclOe, // SCL pulled low while stretching
  input wire logic sdaIn, // SDA pin level
  output logic sdaOut, // SDA drive level
  output logic sdaOe, // SDA pulled low while high
  input wire logic powerFail, // Supply below threshold
  output logic busBlocked, // Bus access inhibited
  output logic haltUpdate, // Clock copy suspended
  output logic wrValid, // Written byte available
  input wire logic wrReady, // Consumer takes written byte
  output rss_wrrec_t wrRec // Written address and data
);
  if (DEPTH < 2 || REC_CYC < 1) begin : g_chk
    $error("rss_slave: DEPTH must be at least 2 and REC_CYC at least 1");
  end

  localparam int CNT_W = $clog2(REC_CYC + 1);
  localparam int IDX_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  // System clock domain: power-fail synchroniser and recovery timer
  logic pfS1, pfS2;
  logic [CNT_W-1:0] recCnt;
  logic block;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pfS1 <= 1'b1;
      pfS2 <= 1'b1;
    end else begin
      pfS1 <= powerFail;
      pfS2 <= pfS1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      recCnt <= CNT_W'(REC_CYC);
      block <= 1'b1;
    end else if (pfS2) begin
      recCnt <= CNT_W'(REC_CYC);
      block <= 1'b1;
    end else if (recCnt != '0) begin
      recCnt <= recCnt - 1'b1;
      block <= 1'b1;
    end else begin
      block <= 1'b0;
    end
  end

  assign busBlocked = block;

  // Link domain reset and control synchronisers
  logic lr1, lrst_n;
  logic bk1, blkL;

  always_ff @(posedge linkClk) begin
    lr1 <= rst_n;
    lrst_n <= lr1;
    bk1 <= block;
    blkL <= bk1;
  end

  logic sclS1, sclS2, sclS3;
  logic sdaS1, sdaS2, sdaS3;

  always_ff @(posedge linkClk) begin
    if (!lrst_n) begin
      sclS1 <= 1'b1;
      sclS2 <= 1'b1;
      sclS3 <= 1'b1;
      sdaS1 <= 1'b1;
      sdaS2 <= 1'b1;
      sdaS3 <= 1'b1;
    end else begin
      sclS1 <= sclIn;
      sclS2 <= sclS1;
      sclS3 <= sclS2;
      sdaS1 <= sdaIn;
      sdaS2 <= sdaS1;
      sdaS3 <= sdaS2;
    end
  end

  logic sclRise, sclFall, startC, stopC;
  assign sclRise = sclS2 & ~sclS3;
  assign sclFall = ~sclS2 & sclS3;
  // SDA edges while SCL stays high are conditions, never data
  assign startC = sclS2 & sclS3 & sdaS3 & ~sdaS2;
  assign stopC = sclS2 & sclS3 & ~sdaS3 & sdaS2;

  // Link domain protocol engine
  rss_state_t state;
  logic [3:0] bitCnt;
  logic [7:0] shreg;
  logic [7:0] txShift;
  logic [PTR_W-1:0] ptr;
  logic rw;
  logic mAck;
  logic drvLow;
  logic [7:0] mem [MEM_BYTES];
  logic wrNow;
  logic byteEnd;

  assign byteEnd = sclFall && (bitCnt == BYTE_BITS);
  assign wrNow = (state == ST_WDAT) && byteEnd;

  always_ff @(posedge linkClk) begin
    if (!lrst_n || blkL) begin
      state <= ST_IDLE;
      bitCnt <= '0;
      shreg <= '0;
      txShift <= '0;
      ptr <= '0;
      rw <= 1'b0;
      mAck <= 1'b0;
      drvLow <= 1'b0;
    end else if (startC) begin
      state <= ST_ADDR;
      bitCnt <= '0;
      drvLow <= 1'b0;
    end else if (stopC) begin
      state <= ST_IDLE;
      drvLow <= 1'b0;
    end else begin
      case (state)
        ST_ADDR, ST_WADR, ST_WDAT: begin
          if (sclRise && bitCnt < BYTE_BITS) begin
            shreg <= {shreg[6:0], sdaS2};
            bitCnt <= bitCnt + 1'b1;
          end else if (byteEnd) begin
            bitCnt <= '0;
            if (state == ST_ADDR) begin
              if (shreg[7:1] == SLAVE_ADDR) begin
                rw <= shreg[0];
                drvLow <= 1'b1;
                state <= ST_ACKA;
              end else begin
                state <= ST_IGN;
              end
            end else if (state == ST_WADR) begin
              ptr <= shreg[PTR_W-1:0];
              drvLow <= 1'b1;
              state <= ST_ACKW;
            end else begin
              drvLow <= 1'b1;
              state <= ST_ACKD;
            end
          end
        end
        ST_ACKA: begin
          if (sclFall) begin
            if (rw) begin
              // Read starts wherever the pointer was left
              txShift <= mem[ptr];
              drvLow <= ~mem[ptr][7];
              state <= ST_RDAT;
            end else begin
              drvLow <= 1'b0;
              state <= ST_WADR;
            end
          end
        end
        ST_ACKW: begin
          if (sclFall) begin
            drvLow <= 1'b0;
            state <= ST_WDAT;
          end
        end
        ST_ACKD: begin
          if (sclRise) begin
            ptr <= ptr + 1'b1;
          end else if (sclFall) begin
            drvLow <= 1'b0;
            state <= ST_WDAT;
          end
        end
        ST_RDAT: begin
          if (sclRise && bitCnt < BYTE_BITS) begin
            bitCnt <= bitCnt + 1'b1;
          end else if (byteEnd) begin
            bitCnt <= '0;
            drvLow <= 1'b0;
            state <= ST_RACK;
          end else if (sclFall) begin
            txShift <= {txShift[6:0], 1'b1};
            drvLow <= ~txShift[6];
          end
        end
        ST_RACK: begin
          if (sclRise) begin
            mAck <= ~sdaS2;
            if (!sdaS2) begin
              ptr <= ptr + 1'b1;
            end
          end else if (sclFall) begin
            if (mAck) begin
              txShift <= mem[ptr];
              drvLow <= ~mem[ptr][7];
              state <= ST_RDAT;
            end else begin
              // Line stays released so the master can issue STOP
              state <= ST_IGN;
            end
          end
        end
        default: begin
          drvLow <= 1'b0;
        end
      endcase
    end
  end

  // Storage; reserved locations hold zero and refuse writes
  always_ff @(posedge linkClk) begin
    if (!lrst_n) begin
      for (int i = 0; i < MEM_BYTES; i++) begin
        mem[i] <= '0;
      end
    end else if (wrNow && !blkL) begin
      if (ptr < RES_FIRST || ptr > RES_LAST) begin
        mem[ptr] <= shreg;
      end
    end
  end

  assign sdaOut = 1'b0;
  assign sdaOe = drvLow;

  // Clock-range halt while an access is open
  logic haltL;
  always_ff @(posedge linkClk) begin
    if (!lrst_n || blkL) begin
      haltL <= 1'b0;
    end else begin
      haltL <= (state != ST_IDLE) && (ptr <= CLK_LAST);
    end
  end

  // Written-byte handshake toward the system clock
  logic ackTgl;
  logic reqTgl, ak1, ak2, busy, stretch;
  rss_wrrec_t recL;
  assign busy = reqTgl ^ ak2;

  always_ff @(posedge linkClk) begin
    if (!lrst_n) begin
      ak1 <= 1'b0;
      ak2 <= 1'b0;
    end else begin
      ak1 <= ackTgl;
      ak2 <= ak1;
    end
  end

  always_ff @(posedge linkClk) begin
    if (!lrst_n) begin
      reqTgl <= 1'b0;
      recL <= '0;
    end else if (wrNow && !blkL && !busy) begin
      recL <= '{addr: ptr, data: shreg};
      reqTgl <= ~reqTgl;
    end
  end

  // Holding SCL low keeps the next byte from arriving before the last one
  // has been taken, so a stalled consumer loses nothing.
  always_ff @(posedge linkClk) begin
    if (!lrst_n || blkL || stopC) begin
      stretch <= 1'b0;
    end else if (state == ST_ACKD && sclFall && busy) begin
      stretch <= 1'b1;
    end else if (!busy) begin
      stretch <= 1'b0;
    end
  end

  assign sclOut = 1'b0;
  assign sclOe = stretch;

  // System clock side: take records into the buffer
  logic rq1, rq2;
  logic hl1, hl2;
  rss_wrrec_t fifo [DEPTH];
  logic [IDX_W-1:0] wp, rp;
  logic [IDX_W:0] cnt;
  logic take, give, full;

  assign full = (cnt == (IDX_W+1)'(DEPTH));
  assign take = (rq2 != ackTgl) && !full;
  assign give = wrValid && wrReady;
  assign wrValid = (cnt != '0);
  assign wrRec = fifo[rp];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rq1 <= 1'b0;
      rq2 <= 1'b0;
      hl1 <= 1'b0;
      hl2 <= 1'b0;
    end else begin
      rq1 <= reqTgl;
      rq2 <= rq1;
      hl1 <= haltL;
      hl2 <= hl1;
    end
  end

  assign haltUpdate = hl2;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ackTgl <= 1'b0;
      wp <= '0;
    end else if (take) begin
      fifo[wp] <= recL;
      ackTgl <= rq2;
      wp <= (wp == IDX_W'(DEPTH - 1)) ? '0 : wp + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rp <= '0;
    end else if (give) begin
      rp <= (rp == IDX_W'(DEPTH - 1)) ? '0 : rp + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt <= '0;
    end else if (take && !give) begin
      cnt <= cnt + 1'b1;
    end else if (give && !take) begin
      cnt <= cnt - 1'b1;
    end
  end
endmodule
`default_nettype wire

// *** dv/rss_slave_properties.sv ***
// Port checker for the two-wire slave access block.
// Bound to every rss_slave; pins are pulled-up wired-AND lines.
`timescale 1ns/10ps
`default_nettype none
module rss_slave_properties
  import rss_pkg::*;
#(
  parameter int REC_CYC = REC_CYCLES
) (
  input wire logic clk, // System clock
  input wire logic rst_n, // Reset, active low
  input wire logic linkClk, // Bus sampling clock
  input wire logic sclIn, // SCL level
  input wire logic sdaIn, // SDA level
  input wire logic sclOe, // SCL stretch
  input wire logic sdaOe, // SDA pull
  input wire logic powerFail, // Supply low
  input wire logic busBlocked, // Bus inhibited
  input wire logic haltUpdate, // Copy halted
  input wire logic wrValid, // Record valid
  input wire logic wrReady, // Record taken
  input wire rss_wrrec_t wrRec // Record
);
  logic [15:0] quiet;
  // Saturates so a long run never wraps into a false early release
  always_ff @(posedge clk) begin
    if (!rst_n || powerFail) quiet <= '0;
    else if (quiet != 16'hFFFF) quiet <= quiet + 16'h0001;
  end
  a_pf_blocks: assert property (@(posedge clk) disable iff (!rst_n)
    powerFail [*4] |-> busBlocked) else $error("bus open in power fail");
  a_blocked_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    busBlocked && $past(busBlocked, 12) |-> !sdaOe) else $error("SDA driven while blocked");
  a_halt_blocked: assert property (@(posedge clk) disable iff (!rst_n)
    busBlocked && $past(busBlocked, 12) |-> !haltUpdate) else $error("halt while blocked");
  a_rec_min: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(busBlocked) |-> quiet >= REC_CYC) else $error("recovery cut short");
  a_sda_hold: assert property (@(posedge linkClk) disable iff (!rst_n)
    sclIn && $past(sclIn) |-> $stable(sdaOe)) else $error("SDA moved with SCL high");
  a_stop_halt: assert property (@(posedge clk) disable iff (!rst_n)
    sclIn && sdaIn && $past(sclIn) && !$past(sdaIn) |-> ##[1:20] !haltUpdate)
    else $error("halt kept after STOP");
  a_rec_steady: assert property (@(posedge clk) disable iff (!rst_n)
    wrValid && !wrReady |=> wrValid && $stable(wrRec)) else $error("record lost");
  a_stretch_low: assert property (@(posedge linkClk) disable iff (!rst_n)
    $rose(sclOe) |-> !$past(sclIn)) else $error("stretch began with SCL high");
endmodule
bind rss_slave rss_slave_properties #(.REC_CYC(REC_CYC)) u_props (.clk(clk), .rst_n(rst_n),
  .linkClk(linkClk), .sclIn(sclIn), .sdaIn(sdaIn), .sclOe(sclOe), .sdaOe(sdaOe),
  .powerFail(powerFail), .busBlocked(busBlocked), .haltUpdate(haltUpdate),
  .wrValid(wrValid), .wrReady(wrReady), .wrRec(wrRec));
`default_nettype wire

// *** dv/rss_master_model.sv ***
// Two-wire bus master model, open-drain levels, 1 = release.
// Assumes the bench resolves each line as a pulled-up wired-AND.
`timescale 1ns/10ps
`default_nettype none
module rss_master_model (
  input wire logic clk, // Pacing clock
  input wire logic scl, // Resolved SCL
  input wire logic sda, // Resolved SDA
  output logic mScl, // Master SCL level
  output logic mSda // Master SDA level
);
  initial begin
    mScl = 1'b1;
    mSda = 1'b1;
  end
  task automatic q();
    repeat (20) @(posedge clk);
  endtask
  // Honours stretching, but gives up so a stuck slave cannot hang us
  task automatic hi();
    int n;
    mScl <= 1'b1;
    n = 0;
    do begin
      q();
      n++;
    end while (scl !== 1'b1 && n < 200);
  endtask
  task automatic start();
    mSda <= 1'b1;
    q();
    hi();
    mSda <= 1'b0;
    q();
    mScl <= 1'b0;
    q();
  endtask
  task automatic stop();
    mSda <= 1'b0;
    q();
    hi();
    q();
    mSda <= 1'b1;
    q();
  endtask
  task automatic bit1(input logic b, output logic r);
    mSda <= b;
    q();
    hi();
    r = sda;
    q();
    mScl <= 1'b0;
    q();
  endtask
  task automatic xfer(input logic [7:0] w, input logic a, output logic [7:0] r,
    output logic s);
    for (int i = 7; i >= 0; i--) bit1(w[i], r[i]);
    bit1(a, s);
  endtask
endmodule
`default_nettype wire

// *** dv/rss_slave_tb.sv ***
// Self-checking bench for the two-wire slave access block.
// Assumes the master model and the bound checker are compiled first.
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, v) begin total_checks++; if ((v) !== (e)) begin n_errors++; \
  $display("[ERR] %s exp %0h got %0h", n, e, v); end end
module rss_slave_tb;
  import rss_pkg::*;
  localparam int REC = 20;
  logic clk = 1'b0, linkClk = 1'b0, rst_n = 1'b0, powerFail = 1'b0, wrReady = 1'b0;
  logic mScl, mSda, sclOe, sdaOe, busBlocked, haltUpdate, wrValid, s, sawStretch = 1'b0;
  logic sclOut, sdaOut;
  logic [7:0] r;
  rss_wrrec_t wrRec;
  rss_wrrec_t got[$];
  int n_errors = 0, total_checks = 0, cyc = 0, stallEnd = 0;
  // Wired-AND with pull-up: an enabled device pin shows its drive level
  wire scl = mScl & (~sclOe | sclOut);
  wire sda = mSda & (~sdaOe | sdaOut);
  rss_slave #(.REC_CYC(REC), .DEPTH(2)) u_dut (.clk(clk), .rst_n(rst_n), .linkClk(linkClk),
    .sclIn(scl), .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .powerFail(powerFail), .busBlocked(busBlocked), .haltUpdate(haltUpdate),
    .wrValid(wrValid), .wrReady(wrReady), .wrRec(wrRec));
  rss_master_model u_m (.clk(clk), .scl(scl), .sda(sda), .mScl(mScl), .mSda(mSda));
  initial forever #10 clk = ~clk;
  initial begin
    #7;
    forever #16 linkClk = ~linkClk;
  end
  // Consumer stalls in windows so the buffer sees back-pressure
  always @(posedge clk) begin
    cyc <= cyc + 1;
    wrReady <= (cyc >= stallEnd) && cyc[9];
    if (sclOe === 1'b1) sawStretch <= 1'b1;
    if (wrValid === 1'b1 && wrReady === 1'b1) got.push_back(wrRec);
  end
  task automatic tx(input logic [7:0] w, input logic ea, input string n);
    u_m.xfer(w, 1'b1, r, s);
    `CHK(n, ea, ~s)
  endtask
  task automatic rx(input logic a, input logic [7:0] e, input string n);
    u_m.xfer(8'hFF, a, r, s);
    `CHK(n, e, r)
  endtask
  task automatic t_write();
    stallEnd <= cyc + 5000;
    u_m.start();
    tx(8'hD0, 1'b1, "addr");
    tx(8'h3E, 1'b1, "word");
    tx(8'hA1, 1'b1, "d0");
    tx(8'hB2, 1'b1, "d1");
    tx(8'hC3, 1'b1, "d2");
    u_m.stop();
    repeat (1200) @(posedge clk);
    `CHK("stretch", 1'b1, sawStretch)
    `CHK("count", 3, got.size())
    `CHK("rec0", {6'h3E, 8'hA1}, got[0])
    `CHK("rec1", {6'h3F, 8'hB2}, got[1])
    `CHK("rec2", {6'h00, 8'hC3}, got[2])
  endtask
  task automatic t_read();
    u_m.start();
    tx(8'hD0, 1'b1, "addr");
    tx(8'h3E, 1'b1, "word");
    u_m.start();
    tx(8'hD1, 1'b1, "raddr");
    rx(1'b0, 8'hA1, "rd0");
    rx(1'b0, 8'hB2, "rd1");
    rx(1'b1, 8'hC3, "rd2");
    repeat (10) @(posedge clk);
    `CHK("release", 1'b1, sda)
    u_m.stop();
  endtask
  task automatic t_cur();
    u_m.start();
    tx(8'hD0, 1'b1, "addr");
    tx(8'h05, 1'b1, "word");
    tx(8'h5A, 1'b1, "d5");
    `CHK("halt", 1'b1, haltUpdate)
    tx(8'h6B, 1'b1, "d6");
    tx(8'h7C, 1'b1, "d7");
    `CHK("resume", 1'b0, haltUpdate)
    u_m.start();
    tx(8'hD0, 1'b1, "addr");
    tx(8'h05, 1'b1, "word");
    u_m.stop();
    u_m.start();
    tx(8'hD1, 1'b1, "raddr");
    rx(1'b1, 8'h5A, "cur");
    u_m.stop();
  endtask
  task automatic t_foreign();
    u_m.start();
    tx(8'hD2, 1'b0, "foreign");
    tx(8'h00, 1'b0, "ignored");
    u_m.stop();
  endtask
  task automatic t_resv();
    u_m.start();
    tx(8'hD0, 1'b1, "addr");
    tx(8'h10, 1'b1, "word");
    tx(8'h55, 1'b1, "dres");
    u_m.start();
    tx(8'hD0, 1'b1, "addr");
    tx(8'h10, 1'b1, "word");
    u_m.start();
    tx(8'hD1, 1'b1, "raddr");
    rx(1'b1, 8'h00, "resv");
    u_m.stop();
  endtask
  task automatic t_pf();
    int n;
    n = got.size();
    u_m.start();
    tx(8'hD0, 1'b1, "addr");
    tx(8'h20, 1'b1, "word");
    powerFail <= 1'b1;
    repeat (10) @(posedge clk);
    `CHK("blocked", 1'b1, busBlocked)
    tx(8'h99, 1'b0, "pfdata");
    powerFail <= 1'b0;
    repeat (REC - 4) @(posedge clk);
    `CHK("recov", 1'b1, busBlocked)
    repeat (20) @(posedge clk);
    `CHK("open", 1'b0, busBlocked)
    u_m.stop();
    u_m.start();
    tx(8'hD1, 1'b1, "raddr");
    rx(1'b1, 8'hC3, "ptr0");
    u_m.stop();
    `CHK("nowrite", n, got.size())
  endtask
  task automatic stop_test();
    if (n_errors == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (REC + 20) @(posedge clk);
    `CHK("unblock", 1'b0, busBlocked)
    t_write();
    t_read();
    t_cur();
    t_foreign();
    t_resv();
    t_pf();
    stop_test();
  end
  initial begin
    repeat (90000) @(posedge clk);
    n_errors++;
    stop_test();
  end
endmodule
`default_nettype wire
